/* File: rtl/umc_top.sv */
// Modem control, modem status, loopback and baud generator of one serial channel.
// What this block does
// - Control bit 0 drives data-terminal-ready, bit 1 drives request-to-send.
// - Control bit 2 drives no output pin; it is looped back as ring in loopback.
// - Bit 3 low: interrupt tristated, general output high; high: driven, low.
// - General output reaches multi-function pin only when select field is 00.
// - Loopback holds serial out high, ignores serial in, feeds transmit to receive.
// - Loopback cuts modem inputs, routes outputs to them, forces output pins high.
// - Loopback modem interrupt sources come from low four control bits.
// - Bits 5 and 1 select full autoflow, clear-to-send only, or none.
// - Reading status clears the change bits, except a change arriving with the read.
// - Status bit 0 flags clear-to-send change; interrupts only without autoflow.
// - Status bit 1 flags data-set-ready change and may raise an interrupt.
// - Status bit 2 flags ring trailing edge and may raise an interrupt.
// - Status bit 3 flags carrier-detect change and may raise an interrupt.
// - Status bits 4 to 7 are complemented clear-to-send, ready, ring, carrier.
// - In loopback status bits 4 to 7 equal control bits 1, 0, 2, 3.
// - Baud generator divides clock by 1 to 65535 giving sixteen times baud.
// - Two byte latches form the divisor; writing either reloads the counter.
//
// Design decisions made here: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
module umc_top
	import umc_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [umc_pkg::UMC_ADDR_W-1:0] i_wb_adr,
	input wire logic [31:0] i_wb_dat,
	input wire logic [3:0] i_wb_sel,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	input wire logic i_cts_n,
	input wire logic i_dsr_n,
	input wire logic i_ri_n,
	input wire logic i_dcd_n,
	output logic o_dtr_n,
	output logic o_rts_n,
	input wire logic i_serial_in,
	input wire logic i_tsr_out,
	output logic o_serial_out,
	output logic o_rsr_in,
	input wire logic i_irq_req,
	input wire logic i_modem_irq_en,
	input wire logic [1:0] i_alt_select,
	output logic o_irq,
	output logic o_irq_oe_n,
	output logic o_multi_function_pin,
	output logic o_modem_irq,
	output logic o_auto_rts_en,
	output logic o_auto_cts_en,
	output logic o_loopback,
	output logic o_baud_tick
);
	import umc_pkg::*;

	logic [7:0] control;
	logic [7:0] div_low;
	logic [7:0] div_high;
	logic [3:0] change;
	logic [7:0] status_value;
	logic bus_req;
	logic wr_en;
	logic rd_status;
	logic div_written;
	logic loop_on;
	logic general_out;
	umc_modem_in_t lines;
	umc_flow_t flow;

	assign bus_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
	assign wr_en = bus_req & i_wb_we & i_wb_sel[0];
	assign loop_on = control[UMC_BIT_LOOP];

	// One wait-free answer per request; the ack drops the following cycle.
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			o_wb_ack <= 1'b0;
		else
			o_wb_ack <= bus_req;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			control <= UMC_CONTROL_RESET;
		else if (wr_en && i_wb_adr == UMC_OFS_CONTROL)
			control <= {2'b00, i_wb_dat[5:0]};
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			div_low <= UMC_DIV_LOW_RESET;
			div_high <= UMC_DIV_HIGH_RESET;
		end
		else if (wr_en && i_wb_adr == UMC_OFS_DIV_LOW)
			div_low <= i_wb_dat[7:0];
		else if (wr_en && i_wb_adr == UMC_OFS_DIV_HIGH)
			div_high <= i_wb_dat[7:0];
	end

	// The counter reloads one cycle after the latch write, from the new value.
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			div_written <= 1'b0;
		else
			div_written <= wr_en && (i_wb_adr == UMC_OFS_DIV_LOW
				|| i_wb_adr == UMC_OFS_DIV_HIGH);
	end

	assign rd_status = bus_req & ~i_wb_we & (i_wb_adr == UMC_OFS_STATUS);

	// Active-high modem input view; in loopback the control bits stand in.
	always_comb
	begin
		if (loop_on)
		begin
			lines.clear_to_send = control[UMC_BIT_RTS];
			lines.data_set_ready = control[UMC_BIT_DTR];
			lines.ring = control[UMC_BIT_OUT_ONE];
			lines.carrier_detect = control[UMC_BIT_OUT_TWO];
		end
		else
		begin
			lines.clear_to_send = ~i_cts_n;
			lines.data_set_ready = ~i_dsr_n;
			lines.ring = ~i_ri_n;
			lines.carrier_detect = ~i_dcd_n;
		end
	end

	umc_change_det u_change
	(
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_lines(lines),
		.i_clear(rd_status),
		.o_change(change)
	);

	assign status_value = {lines.carrier_detect, lines.ring, lines.data_set_ready,
		lines.clear_to_send, change};

	// Read data is registered with the ack; unmapped offsets read as zero.
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			o_wb_dat <= 32'h0000_0000;
		else if (bus_req && !i_wb_we)
		begin
			if (i_wb_adr == UMC_OFS_CONTROL)
				o_wb_dat <= {24'h00_0000, control};
			else if (i_wb_adr == UMC_OFS_STATUS)
				o_wb_dat <= {24'h00_0000, status_value};
			else if (i_wb_adr == UMC_OFS_DIV_LOW)
				o_wb_dat <= {24'h00_0000, div_low};
			else if (i_wb_adr == UMC_OFS_DIV_HIGH)
				o_wb_dat <= {24'h00_0000, div_high};
			else
				o_wb_dat <= 32'h0000_0000;
		end
	end

	always_comb
	begin
		if (!control[UMC_BIT_AUTOFLOW])
			flow = UMC_FLOW_OFF;
		else if (control[UMC_BIT_RTS])
			flow = UMC_FLOW_FULL;
		else
			flow = UMC_FLOW_CTS_ONLY;
	end

	assign o_auto_rts_en = (flow == UMC_FLOW_FULL);
	assign o_auto_cts_en = (flow != UMC_FLOW_OFF);
	assign o_loopback = loop_on;

	// Clear-to-send change is not an interrupt source while autoflow runs.
	assign o_modem_irq = i_modem_irq_en & (change[3] | change[2] | change[1]
		| (change[0] & (flow == UMC_FLOW_OFF)));

	assign o_dtr_n = loop_on ? 1'b1 : ~control[UMC_BIT_DTR];
	assign o_rts_n = loop_on ? 1'b1 : ~control[UMC_BIT_RTS];

	// The general output and the interrupt enable are forced inactive while looped back.
	assign general_out = loop_on ? 1'b1 : ~control[UMC_BIT_OUT_TWO];
	assign o_irq = i_irq_req;
	assign o_irq_oe_n = ~control[UMC_BIT_OUT_TWO] | loop_on;
	assign o_multi_function_pin = (i_alt_select == UMC_SEL_GENERAL_OUT)
		? general_out : 1'b1;

	assign o_serial_out = loop_on ? 1'b1 : i_tsr_out;
	assign o_rsr_in = loop_on ? i_tsr_out : i_serial_in;

	umc_baud_gen #(
		.DIV_W(UMC_DIV_W)
	) u_baud
	(
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_divisor({div_high, div_low}),
		.i_reload(div_written),
		.o_tick(o_baud_tick)
	);
endmodule

/* File: common/umc_pkg.sv */
// Package with register map, field positions and shared types of the modem-control block.
package umc_pkg;
	localparam int unsigned UMC_ADDR_W = 4;
	localparam logic [3:0] UMC_OFS_CONTROL = 4'h0;
	localparam logic [3:0] UMC_OFS_STATUS = 4'h4;
	localparam logic [3:0] UMC_OFS_DIV_LOW = 4'h8;
	localparam logic [3:0] UMC_OFS_DIV_HIGH = 4'hc;
	localparam logic [7:0] UMC_CONTROL_RESET = 8'h00;
	localparam logic [7:0] UMC_DIV_LOW_RESET = 8'h01;
	localparam logic [7:0] UMC_DIV_HIGH_RESET = 8'h00;
	localparam logic [1:0] UMC_SEL_RESET = 2'h0;
	localparam logic [1:0] UMC_SEL_GENERAL_OUT = 2'h0;
	localparam int unsigned UMC_BIT_DTR = 0;
	localparam int unsigned UMC_BIT_RTS = 1;
	localparam int unsigned UMC_BIT_OUT_ONE = 2;
	localparam int unsigned UMC_BIT_OUT_TWO = 3;
	localparam int unsigned UMC_BIT_LOOP = 4;
	localparam int unsigned UMC_BIT_AUTOFLOW = 5;
	localparam int unsigned UMC_DIV_W = 16;
	localparam int unsigned UMC_OVERSAMPLE = 16;

	// Modem lines as seen by the status logic, one bit each, active high.
	typedef struct packed {
		logic carrier_detect;
		logic ring;
		logic data_set_ready;
		logic clear_to_send;
	} umc_modem_in_t;

	// Flow mode decoded from the control register.
	typedef enum logic [2:0] {
		UMC_FLOW_OFF = 3'b001,
		UMC_FLOW_CTS_ONLY = 3'b010,
		UMC_FLOW_FULL = 3'b100
	} umc_flow_t;
endpackage

/* File: rtl/umc_baud_gen.sv */
// Baud generator that divides the clock by a 16-bit divisor into a 16x enable pulse.
`timescale 1ns/1ps
module umc_baud_gen
	import umc_pkg::*;
#(
	parameter int unsigned DIV_W = umc_pkg::UMC_DIV_W
)
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [DIV_W-1:0] i_divisor,
	input wire logic i_reload,
	output logic o_tick
);
	logic [DIV_W-1:0] count;

	initial
	begin
		if (DIV_W < 2)
			$error("umc_baud_gen: divisor width too small");
	end

	// A divisor of zero is treated as one so the enable never stops.
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			count <= '0;
			o_tick <= 1'b0;
		end
		else if (i_reload)
		begin
			count <= i_divisor;
			o_tick <= 1'b0;
		end
		else if (count <= {{(DIV_W-1){1'b0}}, 1'b1})
		begin
			count <= i_divisor;
			o_tick <= 1'b1;
		end
		else
		begin
			count <= count - {{(DIV_W-1){1'b0}}, 1'b1};
			o_tick <= 1'b0;
		end
	end
endmodule

/* File: rtl/umc_change_det.sv */
// Sticky change detector for the four modem inputs, cleared by a status read.
`timescale 1ns/1ps
module umc_change_det
	import umc_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire umc_pkg::umc_modem_in_t i_lines,
	input wire logic i_clear,
	output logic [3:0] o_change
);
	umc_modem_in_t last;
	logic [3:0] event_now;

	always_comb
	begin
		event_now[0] = i_lines.clear_to_send ^ last.clear_to_send;
		event_now[1] = i_lines.data_set_ready ^ last.data_set_ready;
		event_now[2] = last.ring & ~i_lines.ring;
		event_now[3] = i_lines.carrier_detect ^ last.carrier_detect;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			last <= '0;
		else
			last <= i_lines;
	end

	// A change arriving with the read is kept so no edge is lost.
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			o_change <= 4'h0;
		else if (i_clear)
			o_change <= event_now;
		else
			o_change <= o_change | event_now;
	end
endmodule

/* File: dv/umc_props.sv */
// Port-level checker of the modem-control block.
`timescale 1ns/1ps
module umc_props
	import umc_pkg::*;
(
	input wire logic i_clk, i_rst, i_wb_cyc, i_wb_stb, o_wb_ack,
	input wire logic [31:0] o_wb_dat,
	input wire logic o_dtr_n, o_rts_n, o_irq_oe_n, o_loopback,
	input wire logic i_serial_in, i_tsr_out, o_serial_out, o_rsr_in,
	input wire logic [1:0] i_alt_select,
	input wire logic o_multi_function_pin, o_auto_rts_en, o_auto_cts_en,
	input wire logic i_modem_irq_en, o_modem_irq, i_irq_req, o_irq
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	loop_pins_a: assert property (o_loopback |-> o_dtr_n && o_rts_n && o_irq_oe_n)
		else $error("handshake pin active in loopback");
	loop_serial_a: assert property (o_loopback |-> o_serial_out && o_rsr_in == i_tsr_out)
		else $error("serial path wrong in loopback");
	norm_serial_a: assert property (!o_loopback |-> o_rsr_in == i_serial_in)
		else $error("receive path wrong");
	mf_other_a: assert property (i_alt_select != 2'h0 |-> o_multi_function_pin)
		else $error("general output leaks to pin");
	mf_general_a: assert property (i_alt_select == 2'h0 |-> o_multi_function_pin == o_irq_oe_n)
		else $error("general output disagrees with enable");
	flow_mode_a: assert property (o_auto_rts_en |-> o_auto_cts_en && (o_loopback || !o_rts_n))
		else $error("flow mode decode wrong");
	irq_gate_a: assert property (!i_modem_irq_en |-> !o_modem_irq)
		else $error("modem interrupt while disabled");
	irq_pass_a: assert property (o_irq == i_irq_req)
		else $error("interrupt request not passed");
	ack_pulse_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack ##1 !o_wb_ack)
		else $error("ack not a one cycle answer");
	rd_upper_a: assert property (o_wb_ack |-> o_wb_dat[31:8] == 24'h0)
		else $error("read data upper bits set");
endmodule

/* File: dv/umc_modem.sv */
// Behavioural data set driving the handshake inputs and the serial line.
`timescale 1ns/1ps
module umc_modem
(
	input wire logic i_clk,
	input wire logic [3:0] i_want,
	output logic o_cts_n,
	output logic o_dsr_n,
	output logic o_ri_n,
	output logic o_dcd_n,
	output logic o_rx
);
	initial o_rx = 1'b1;
	always @(posedge i_clk)
	begin
		{o_dcd_n, o_ri_n, o_dsr_n, o_cts_n} <= ~i_want;
		// The line toggles so a stale level can never pass for looped data.
		o_rx <= ~o_rx;
	end
endmodule

/* File: dv/umc_top_bench.sv */
// Self-checking bench of the modem-control block.
`timescale 1ns/1ps
module umc_top_bench;
	import umc_pkg::*;
	logic i_clk = 1'b0, i_rst = 1'b1, i_wb_cyc = 1'b0, i_wb_stb = 1'b0, i_wb_we = 1'b0;
	logic [3:0] i_wb_adr = 4'h0, i_wb_sel = 4'hf, want = 4'h0, pv, lv;
	logic [31:0] i_wb_dat = 32'h0, o_wb_dat;
	logic i_tsr_out = 1'b1, i_irq_req = 1'b0, i_modem_irq_en = 1'b0;
	logic [1:0] i_alt_select = 2'h0;
	logic o_wb_ack, i_cts_n, i_dsr_n, i_ri_n, i_dcd_n, o_dtr_n, o_rts_n, i_serial_in;
	logic o_serial_out, o_rsr_in, o_irq, o_irq_oe_n, o_multi_function_pin, o_modem_irq;
	logic o_auto_rts_en, o_auto_cts_en, o_loopback, o_baud_tick;
	logic [7:0] c, q, s;
	int errors = 0, checks_done = 0, cycles = 0, n, k;
	wire [7:0] pins = {1'b0, o_loopback, o_auto_cts_en, o_auto_rts_en,
		o_multi_function_pin, o_irq_oe_n, o_rts_n, o_dtr_n};
	umc_top dut (.*);
	umc_modem peer (.i_clk(i_clk), .i_want(want), .o_cts_n(i_cts_n), .o_dsr_n(i_dsr_n),
		.o_ri_n(i_ri_n), .o_dcd_n(i_dcd_n), .o_rx(i_serial_in));
	initial forever #4 i_clk = ~i_clk;
	task test_done;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	always @(posedge i_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			errors++;
			test_done();
		end
	end
	task chk(input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e)
		begin
			errors++;
			$display("BAD %0t exp %h got %h", $time, e, g);
		end
	endtask
	task wb(input logic w, input logic [3:0] a, input logic [7:0] d);
		@(posedge i_clk);
		{i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_dat} <= {2'b11, w, a, 24'h0, d};
		k = 0;
		do @(posedge i_clk); while (o_wb_ack !== 1'b1 && ++k < 40);
		if (k == 40)
			errors++;
		q = o_wb_dat[7:0];
		{i_wb_cyc, i_wb_stb} <= 2'b00;
	endtask
	task gap;
		k = 0;
		do @(posedge i_clk); while (o_baud_tick !== 1'b1 && ++k < 300);
	endtask
	function automatic logic [7:0] pexp(input logic [7:0] v, input logic [1:0] a);
		return {1'b0, v[4], v[5], v[5] & v[1], (a == 2'h0) ? v[4] | ~v[3] : 1'b1,
			v[4] | ~v[3], v[4] | ~v[1], v[4] | ~v[0]};
	endfunction
	function automatic logic [7:0] sexp(input logic [3:0] p, input logic [3:0] v);
		return {v, v[3] ^ p[3], p[2] & ~v[2], v[1] ^ p[1], v[0] ^ p[0]};
	endfunction
	initial
	begin
		void'($urandom(32'h2397c99e));
		repeat (2) @(posedge i_clk);
		i_rst <= 1'b0;
		wb(0, UMC_OFS_CONTROL, 0);
		chk(UMC_CONTROL_RESET, q);
		wb(0, UMC_OFS_STATUS, 0);
		chk(8'h00, q);
		chk(pexp(8'h00, 2'h0), pins);
		wb(0, 4'h2, 8'h00);
		chk(8'h00, q);
		$display("test reset done");
		for (int i = 0; i < 14; i++)
		begin
			c = (i < 2) ? (i ? 8'h1f : 8'h22) : 8'($urandom);
			{i_alt_select, i_tsr_out, i_irq_req, i_modem_irq_en} <= 5'($urandom);
			wb(1, UMC_OFS_CONTROL, c);
			chk(pexp(c, i_alt_select), pins);
			wb(0, UMC_OFS_CONTROL, 0);
			chk(c & 8'h3f, q);
			wb(0, UMC_OFS_STATUS, 0);
			pv = c[4] ? {c[3], c[2], c[0], c[1]} : want;
			lv = 4'($urandom);
			want <= lv;
			repeat (6) @(posedge i_clk);
			s = sexp(pv, c[4] ? pv : lv);
			chk({7'h0, i_modem_irq_en & (|s[3:1] | s[0] & ~c[5])}, {7'h0, o_modem_irq});
			wb(0, UMC_OFS_STATUS, 0);
			chk(s, q);
			wb(0, UMC_OFS_STATUS, 0);
			chk(s & 8'hf0, q);
		end
		i_wb_sel <= 4'he;
		wb(1, UMC_OFS_CONTROL, ~c);
		i_wb_sel <= 4'hf;
		wb(0, UMC_OFS_CONTROL, 0);
		chk(c & 8'h3f, q);
		$display("test modem done");
		for (int i = 0; i < 3; i++)
		begin
			n = i ? 2 + $urandom % 9 : 1;
			// Latches sit at their own offsets, so no access bit is set first.
			wb(1, UMC_OFS_DIV_HIGH, 8'h01);
			wb(1, UMC_OFS_DIV_LOW, 8'(n));
			wb(1, UMC_OFS_DIV_HIGH, 8'h00);
			// Reload follows the ack edge, so the first tick comes n edges later.
			gap();
			chk(8'(n), 8'(k));
			// Ticks are n cycles apart; the wait loop counts one edge fewer.
			gap();
			chk(8'(n - 1), 8'(k));
		end
		$display("test baud done");
		test_done();
	end
endmodule
bind umc_top umc_props chk_u (.*);
